// file: hw/rivc_core.sv
// Purpose: reset and interrupt vector selection with system options register
// Assumes: E clock is the 200 MHz clk_i; request pins are asynchronous
// Notes:   APB slave for options, promotion, keyboard status and enables
//
// Contract
// - three reset vectors separate from interrupt vectors
// - thirty sources behind eighteen vectors
// - maskable requests need global mask clear
// - each maskable source gated by local enable, except handshake
// - promotion writable only while mask set
// - external, keyboard, handshake share level-5 vector
// - keyboard status clears when read
// - receive-full clears after status then data read
// - serial vector combines five enabled flags
// - fixed vectors for serial, accumulator, timer, periodic
// - timer channel vectors ranked eight to seventeen
// - nonmaskable pin gated by X; traps unmaskable
// - reset vectors: external, clock monitor, watchdog
// - once-bits writable once in first 64 cycles
// - edge-select picks level or falling edge
// - stop-exit delay when delay bit set
// - clock monitor enable arms failure reset on long-held slow indication
// - watchdog rate divides by 2^15..2^21
// - bit two reads zero; reset value 0x10
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "rivc_defines.svh"

module rivc_core
    import rivc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              irq_n_pin_i,
    input  wire logic [6:0]        keyboard_irq_n_i,
    input  wire logic              nonmaskable_request_pin_n_i,
    input  wire logic              ext_reset_n_i,
    input  wire logic              clk_slow_i,
    input  wire logic              i_mask_i,
    input  wire logic              x_mask_i,
    input  wire logic              swi_i,
    input  wire logic              illegal_op_i,
    input  wire logic              special_mode_i,
    input  wire logic              watchdog_disable_i,
    input  wire logic              watchdog_service_i,
    input  wire logic              stop_i,
    input  wire logic              stop_wake_i,
    input  wire rivc_sci_t         sci_i,
    input  wire rivc_periph_t      periph_i,
    output logic      [15:0]       vector_o,
    output logic                   vector_valid_o,
    output logic                   reset_req_o,
    output logic                   clock_run_o
);

    logic [1:0]  irq_sync_r;
    logic [1:0]  nmi_sync_r;
    logic [1:0]  rst_sync_r;
    logic [1:0]  slow_sync_r;
    logic [13:0] kb_sync_r;
    logic        irq_prev_r;
    logic        irq_edge_seen_r;
    logic [7:0]  options_r;
    logic        once_done_r;
    logic [6:0]  age_r;
    logic [3:0]  promo_r;
    logic [7:0]  kb_status_r;
    logic [6:0]  keyboard_irq_enables_r;
    logic        irq_enable_r;
    logic [4:0]  sci_en_r;      // receive, tx empty, tx done, idle, spare
    logic [13:0] periph_en_r;
    logic        receive_full_flag_r;
    logic        sts_armed_r;
    logic [20:0] wd_cnt_r;
    logic        wd_fail_r;
    logic [7:0]  slow_cnt_r;
    logic        clkmon_fail_r;
    rivc_stop_t  stop_st_r;
    logic [11:0] osc_cnt_r;
    logic [31:0] rd_nxt;
    logic [15:0] vec_nxt;
    logic        vec_valid_nxt;
    logic        reset_nxt;
    logic [4:0]  best_lvl;
    logic [4:0]  lvl;
    logic [15:0] best_vec;
    logic [15:0] req_vec   [15];
    logic [4:0]  req_lvl   [15];
    logic [14:0] req_act;
    logic [3:0]  req_code  [15];
    logic        access;
    logic        wr;
    logic        rd;
    logic        kb_read;
    logic [6:0]  kb_fall;
    logic        irq_active;
    logic        dly_busy;

    assign access = psel_i & penable_i & pready_o;   // acted on once, at the ready edge
    assign wr     = access & pwrite_i;
    assign rd     = access & ~pwrite_i;
    assign kb_read = rd && (paddr_i == `RIVC_KBST_ADDR);

    // pins pass two flops before any use
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_sync_r  <= 2'b11;
            nmi_sync_r  <= 2'b11;
            rst_sync_r  <= 2'b11;
            slow_sync_r <= 2'b00;
            kb_sync_r   <= 14'h3FFF;
        end else begin
            irq_sync_r  <= {irq_sync_r[0], irq_n_pin_i};
            nmi_sync_r  <= {nmi_sync_r[0], nonmaskable_request_pin_n_i};
            rst_sync_r  <= {rst_sync_r[0], ext_reset_n_i};
            slow_sync_r <= {slow_sync_r[0], clk_slow_i};
            kb_sync_r   <= {kb_sync_r[6:0], keyboard_irq_n_i};
        end
    end

    // external request: level or latched falling edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_prev_r      <= 1'b1;
            irq_edge_seen_r <= 1'b0;
        end else begin
            irq_prev_r <= irq_sync_r[1];
            if (irq_prev_r && !irq_sync_r[1])
                irq_edge_seen_r <= 1'b1;
            else if (vector_valid_o && vector_o == `RIVC_VEC_IRQ)
                irq_edge_seen_r <= 1'b0;
        end
    end
    assign irq_active = options_r[`RIVC_BIT_EDGE] ? irq_edge_seen_r : ~irq_sync_r[1];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            options_r   <= `RIVC_OPT_RESET;
            once_done_r <= 1'b0;
            age_r       <= 7'd0;
        end else begin
            if (age_r != `RIVC_ONCE_WINDOW)
                age_r <= age_r + 7'd1;
            if (wr && paddr_i == `RIVC_OPT_ADDR) begin
                if (special_mode_i || (!once_done_r && age_r < `RIVC_ONCE_WINDOW)) begin
                    options_r   <= pwdata_i[7:0] & `RIVC_OPT_MASK;
                    once_done_r <= 1'b1;
                end else begin
                    options_r <= (options_r & `RIVC_OPT_ONCE_MASK)
                               | (pwdata_i[7:0] & `RIVC_OPT_MASK & ~`RIVC_OPT_ONCE_MASK);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            promo_r                <= `RIVC_PROMO_RESET;
            keyboard_irq_enables_r <= 7'h00;
            irq_enable_r           <= 1'b0;
            sci_en_r               <= 5'h00;
            periph_en_r            <= 14'h0000;
        end else if (wr) begin
            if (paddr_i == `RIVC_PROMO_ADDR && i_mask_i)
                promo_r <= pwdata_i[3:0];
            if (paddr_i == `RIVC_SRCEN_ADDR) begin
                keyboard_irq_enables_r <= pwdata_i[6:0];
                irq_enable_r           <= pwdata_i[7];
                sci_en_r               <= pwdata_i[12:8];
                periph_en_r            <= pwdata_i[26:13];
            end
        end
    end

    // keyboard status, set wins over read clear
    assign kb_fall = ~kb_sync_r[13:7] & keyboard_irq_enables_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            kb_status_r <= 8'h00;
        else
            kb_status_r <= (kb_read ? 8'h00 : kb_status_r)
                         | {irq_enable_r & irq_active, kb_fall};
    end

    // receive-full: status read while set, then data read
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            receive_full_flag_r      <= 1'b0;
            sts_armed_r <= 1'b0;
        end else begin
            if (rd && paddr_i == `RIVC_SCIST_ADDR && receive_full_flag_r)
                sts_armed_r <= 1'b1;
            else if (rd && paddr_i == `RIVC_SCIDAT_ADDR)
                sts_armed_r <= 1'b0;
            if (sci_i.receive_full_flag)
                receive_full_flag_r <= 1'b1;
            else if (rd && paddr_i == `RIVC_SCIDAT_ADDR && sts_armed_r)
                receive_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_cnt_r  <= 21'd0;
            wd_fail_r <= 1'b0;
        end else if (watchdog_service_i || watchdog_disable_i) begin
            wd_cnt_r  <= 21'd0;
            wd_fail_r <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 21'd1;
            if (wd_cnt_r == 21'((22'd1 << (`RIVC_WD_BASE + 2 * options_r[1:0])) - 22'd1))
                wd_fail_r <= 1'b1;
        end
    end

    // clock monitor: a long-held slow indication is a failure
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slow_cnt_r    <= 8'd0;
            clkmon_fail_r <= 1'b0;
        end else if (!options_r[`RIVC_BIT_CME] || !slow_sync_r[1]) begin
            slow_cnt_r    <= 8'd0;
            clkmon_fail_r <= 1'b0;
        end else if (slow_cnt_r == `RIVC_CLKMON_LIMIT) begin
            clkmon_fail_r <= 1'b1;
        end else begin
            slow_cnt_r <= slow_cnt_r + 8'd1;
        end
    end

    assign dly_busy = (stop_st_r == RIVC_WAKE);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stop_st_r <= RIVC_RUN;
            osc_cnt_r <= 12'd0;
        end else begin
            case (stop_st_r)
                RIVC_RUN:
                    if (stop_i)
                        stop_st_r <= RIVC_STOPPED;
                RIVC_STOPPED:
                    if (stop_wake_i) begin
                        osc_cnt_r <= 12'd0;
                        stop_st_r <= options_r[`RIVC_BIT_DLY] ? RIVC_WAKE
                                                             : RIVC_RUN;
                    end
                RIVC_WAKE:
                    if (osc_cnt_r == `RIVC_OSC_DELAY - 12'd1)
                        stop_st_r <= RIVC_RUN;
                    else
                        osc_cnt_r <= osc_cnt_r + 12'd1;
                default:
                    stop_st_r <= RIVC_RUN;
            endcase
        end
    end

    // maskable source table: vector, level, promotion code, request
    always_comb begin
        req_vec[0]  = `RIVC_VEC_SCI;    req_lvl[0]  = 5'd23; req_code[0]  = 4'h4;
        req_vec[1]  = `RIVC_VEC_SPI;    req_lvl[1]  = 5'd22; req_code[1]  = 4'h3;
        req_vec[2]  = `RIVC_VEC_PAEDGE; req_lvl[2]  = 5'd21; req_code[2]  = 4'h2;
        req_vec[3]  = `RIVC_VEC_PAOV;   req_lvl[3]  = 5'd20; req_code[3]  = 4'h1;
        req_vec[4]  = `RIVC_VEC_TOV;    req_lvl[4]  = 5'd19; req_code[4]  = 4'h0;
        req_vec[5]  = `RIVC_VEC_SHARED; req_lvl[5]  = 5'd17; req_code[5]  = 4'hF;
        req_vec[13] = `RIVC_VEC_RTI;    req_lvl[13] = 5'd7;  req_code[13] = 4'h7;
        req_vec[14] = `RIVC_VEC_IRQ;    req_lvl[14] = 5'd5;  req_code[14] = 4'h6;
        for (int k = 0; k < 7; k++) begin
            req_vec[6 + k]  = 16'(`RIVC_VEC_IC1 - 16'd12 + 16'd2 * 16'(k));
            req_lvl[6 + k]  = 5'(14 - k);
            req_code[6 + k] = 4'(4'hE - 4'(k));
        end
        req_act[0]  = (receive_full_flag_r | sci_i.overrun) & sci_en_r[0]
                    | sci_i.tx_empty & sci_en_r[1]
                    | sci_i.tx_done & sci_en_r[2]
                    | sci_i.idle_line & sci_en_r[3];
        req_act[1]  = periph_i.spi_done & periph_en_r[0];
        req_act[2]  = periph_i.pa_edge & periph_en_r[1];
        req_act[3]  = periph_i.pa_ovf & periph_en_r[2];
        req_act[4]  = periph_i.tov & periph_en_r[3];
        req_act[5]  = periph_i.ic_oc[7] & periph_en_r[4];
        for (int k = 0; k < 7; k++)
            req_act[6 + k] = periph_i.ic_oc[6 - k] & periph_en_r[5 + k];
        req_act[13] = periph_i.rti & periph_en_r[12];
        req_act[14] = periph_i.handshake | (|kb_status_r);
        if (i_mask_i)
            req_act = 15'h0000;
    end

    // arbitration: lowest level wins, promoted source above all maskable
    always_comb begin
        best_lvl = 5'd31;
        best_vec = `RIVC_VEC_NONE;
        for (int k = 0; k < 15; k++) begin
            lvl = (req_code[k] == promo_r || (k == 14 && promo_r == 4'h5)) ? 5'd0 : req_lvl[k];
            if (req_act[k] && lvl <= best_lvl) begin
                best_lvl = lvl;
                best_vec = req_vec[k];
            end
        end
        reset_nxt     = ~rst_sync_r[1] | clkmon_fail_r | wd_fail_r;
        vec_valid_nxt = 1'b1;
        if (!rst_sync_r[1])
            vec_nxt = `RIVC_VEC_RESET;
        else if (clkmon_fail_r)
            vec_nxt = `RIVC_VEC_CLKMON;
        else if (wd_fail_r)
            vec_nxt = `RIVC_VEC_WDOG;
        else if (illegal_op_i)
            vec_nxt = `RIVC_VEC_ILLOP;
        else if (swi_i)
            vec_nxt = `RIVC_VEC_SWI;
        else if (!nmi_sync_r[1] && !x_mask_i)
            vec_nxt = `RIVC_VEC_NMI;
        else begin
            vec_nxt       = best_vec;
            vec_valid_nxt = (best_lvl != 5'd31) && !dly_busy;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vector_o       <= `RIVC_VEC_RESET;
            vector_valid_o <= 1'b0;
            reset_req_o    <= 1'b1;
            clock_run_o    <= 1'b1;
        end else begin
            vector_o       <= vec_nxt;
            vector_valid_o <= vec_valid_nxt;
            reset_req_o    <= reset_nxt;
            clock_run_o    <= (stop_st_r == RIVC_RUN);
        end
    end

    always_comb begin
        case (paddr_i)
            `RIVC_OPT_ADDR:    rd_nxt = {24'h000000, options_r};
            `RIVC_PROMO_ADDR:  rd_nxt = {28'h0000000, promo_r};
            `RIVC_KBST_ADDR:   rd_nxt = {24'h000000, kb_status_r};
            `RIVC_SRCEN_ADDR:  rd_nxt = {5'h00, periph_en_r, sci_en_r,
                                         irq_enable_r, keyboard_irq_enables_r};
            `RIVC_VEC_ADDR:    rd_nxt = {15'h0000, vector_valid_o, vector_o};
            `RIVC_SCIST_ADDR:  rd_nxt = {31'h00000000, receive_full_flag_r};
            `RIVC_CTRL_ADDR:   rd_nxt = {30'h00000000, stop_st_r};
            default:           rd_nxt = 32'h0000_0000;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            prdata_o  <= rd_nxt;
            pslverr_o <= psel_i & penable_i & ~pready_o & (paddr_i > `RIVC_CTRL_ADDR);
        end
    end

endmodule : rivc_core

// file: hw/rivc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef RIVC_DEFINES_SVH
`define RIVC_DEFINES_SVH

// printed offset 0x39 is not a multiple of four: index kept, byte address is 4x
`define RIVC_OPT_IDX        8'h39
`define RIVC_OPT_ADDR       12'h0E4
`define RIVC_PROMO_ADDR     12'h0E8
`define RIVC_KBST_ADDR      12'h0EC
`define RIVC_SRCEN_ADDR     12'h0F0
`define RIVC_VEC_ADDR       12'h0F4
`define RIVC_SCIST_ADDR     12'h0F8
`define RIVC_SCIDAT_ADDR    12'h0FC
`define RIVC_CTRL_ADDR      12'h100

`define RIVC_OPT_RESET      8'h10
`define RIVC_OPT_MASK       8'hFB
`define RIVC_OPT_ONCE_MASK  8'h33
`define RIVC_BIT_EDGE       5
`define RIVC_BIT_DLY        4
`define RIVC_BIT_CME        3
`define RIVC_PROMO_RESET    4'h6

`define RIVC_ONCE_WINDOW    7'd64
`define RIVC_OSC_DELAY      12'd4064
`define RIVC_CLKMON_LIMIT   8'd200
`define RIVC_WD_BASE        15

`define RIVC_VEC_RESET      16'hFFFE
`define RIVC_VEC_CLKMON     16'hFFFC
`define RIVC_VEC_WDOG       16'hFFFA
`define RIVC_VEC_ILLOP      16'hFFF8
`define RIVC_VEC_SWI        16'hFFF6
`define RIVC_VEC_NMI        16'hFFF4
`define RIVC_VEC_IRQ        16'hFFF2
`define RIVC_VEC_RTI        16'hFFF0
`define RIVC_VEC_IC1        16'hFFEE
`define RIVC_VEC_SHARED     16'hFFE0
`define RIVC_VEC_TOV        16'hFFDE
`define RIVC_VEC_PAOV       16'hFFDC
`define RIVC_VEC_PAEDGE     16'hFFDA
`define RIVC_VEC_SPI        16'hFFD8
`define RIVC_VEC_SCI        16'hFFD6
`define RIVC_VEC_NONE       16'h0000

`endif

// file: hw/rivc_pkg.sv
// Purpose: types shared by the vectoring block
// Assumes: constants live in rivc_defines.svh
// Notes:   none
package rivc_pkg;
    typedef struct packed {
        logic       receive_full_flag;
        logic       overrun;
        logic       tx_empty;
        logic       tx_done;
        logic       idle_line;
    } rivc_sci_t;

    typedef struct packed {
        logic [7:0] ic_oc;      // ic1..ic3 at 2:0, oc1..oc4 at 6:3, shared at 7
        logic       tov;
        logic       pa_ovf;
        logic       pa_edge;
        logic       spi_done;
        logic       rti;
        logic       handshake;
    } rivc_periph_t;

    typedef enum logic [1:0] {
        RIVC_RUN,
        RIVC_STOPPED,
        RIVC_WAKE
    } rivc_stop_t;
endpackage : rivc_pkg

// file: bench/rivc_core_asserts.sv
// Purpose: port checks of the reset and vector block
// Assumes: vector and pready registered one cycle after their cause
// Notes:   bound from the testbench top
`timescale 1ns/1ps
`include "rivc_defines.svh"

module rivc_core_asserts
    import rivc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        i_mask_i,
    input wire logic        x_mask_i,
    input wire logic        swi_i,
    input wire logic        ext_reset_n_i,
    input wire logic [15:0] vector_o,
    input wire logic        vector_valid_o,
    input wire logic        reset_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    reset_vec_a: assert property ($fell(ext_reset_n_i) |-> ##[1:4]
        (reset_req_o && vector_o == `RIVC_VEC_RESET)) else $error("reset vector missing");
    apb_answer_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("no ready after access");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
    ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without access");
    opt_bit2_a: assert property (pready_o && !pwrite_i && paddr_i == `RIVC_OPT_ADDR
        |-> prdata_o[2] == 1'b0) else $error("options bit 2 not zero");
    unmapped_err_a: assert property (pready_o && paddr_i > 12'h100 |-> pslverr_o)
        else $error("no error on unmapped");
    mask_gate_a: assert property (vector_valid_o && vector_o <= `RIVC_VEC_IRQ
        && vector_o >= `RIVC_VEC_SCI |-> !$past(i_mask_i)) else $error("maskable while masked");
    nmi_gate_a: assert property (vector_valid_o && vector_o == `RIVC_VEC_NMI
        |-> !$past(x_mask_i)) else $error("nonmaskable while X set");
    swi_cause_a: assert property (vector_valid_o && vector_o == `RIVC_VEC_SWI
        |-> $past(swi_i)) else $error("trap vector without request");

    kb_vec_c: cover property (vector_valid_o && vector_o == `RIVC_VEC_IRQ);
    nmi_vec_c: cover property (vector_valid_o && vector_o == `RIVC_VEC_NMI);
    opt_read_c: cover property (pready_o && paddr_i == `RIVC_OPT_ADDR);
endmodule : rivc_core_asserts

// file: bench/rivc_cpu_model.sv
// Purpose: core and peripheral side: masks, traps and request lines
// Assumes: all outputs change just after a rising edge
// Notes:   behavioural, steered by the testbench
`timescale 1ns/1ps

module rivc_cpu_model
    import rivc_pkg::*;
(
    input  wire logic   clk_i,
    output logic        i_mask_o,
    output logic        x_mask_o,
    output logic        swi_o,
    output logic        nmi_n_o,
    output logic [6:0]  kb_n_o,
    output rivc_sci_t   sci_o,
    output rivc_periph_t periph_o
);
    initial begin
        {i_mask_o, x_mask_o, swi_o, nmi_n_o, kb_n_o} = {4'hD, 7'h7F};
        sci_o = '0;
        periph_o = '0;
    end

    // each drive call sets mask, trap, pin and request levels; they hold until the next call
    task drive(input logic im, xm, sw, nm, input logic [6:0] kb, input rivc_periph_t p);
        @(posedge clk_i);
        i_mask_o <= im;
        x_mask_o <= xm;
        swi_o    <= sw;
        nmi_n_o  <= nm;
        kb_n_o   <= kb;
        periph_o <= p;
    endtask : drive

    task async_serial_port(input rivc_sci_t s);
        @(posedge clk_i);
        sci_o <= s;
    endtask : async_serial_port
endmodule : rivc_cpu_model

// file: bench/test_reset_interrupt_vector_control.sv
// Purpose: self-checking bench for the reset and vector block
// Assumes: APB answers one cycle into access; vector one cycle after cause
// Notes:   watchdog disabled and stop unused
`timescale 1ns/1ps
`include "rivc_defines.svh"

module test_reset_interrupt_vector_control;
    import rivc_pkg::*;
    logic clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, last_err, ext_n = 1, slow = 0, irq_n = 1, illop = 0;
    logic i_mask, x_mask, swi, nmi_n, vvalid, rreq;
    logic [6:0] kb_n;
    logic [15:0] vec;
    rivc_sci_t async_serial_port;
    rivc_periph_t per;
    int errors = 0, comparisons = 0, cycles = 0;
    logic [13:0] src [8] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008,
                             14'h0010, 14'h0020, 14'h0040, 14'h2000};
    logic [15:0] exv [8] = '{`RIVC_VEC_IRQ, `RIVC_VEC_RTI, `RIVC_VEC_SPI, `RIVC_VEC_PAEDGE,
                             `RIVC_VEC_PAOV, `RIVC_VEC_TOV, `RIVC_VEC_IC1, `RIVC_VEC_SHARED};

    initial forever #2.5 clk_i = ~clk_i;

    rivc_cpu_model cpu (.clk_i(clk_i), .i_mask_o(i_mask), .x_mask_o(x_mask), .swi_o(swi),
        .nmi_n_o(nmi_n), .kb_n_o(kb_n), .sci_o(async_serial_port), .periph_o(per));

    rivc_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_n_pin_i(irq_n), .keyboard_irq_n_i(kb_n),
        .nonmaskable_request_pin_n_i(nmi_n), .ext_reset_n_i(ext_n), .clk_slow_i(slow),
        .i_mask_i(i_mask), .x_mask_i(x_mask), .swi_i(swi), .illegal_op_i(illop),
        .special_mode_i(1'b0), .watchdog_disable_i(1'b1), .watchdog_service_i(1'b0),
        .stop_i(1'b0), .stop_wake_i(1'b0), .sci_i(async_serial_port), .periph_i(per), .vector_o(vec),
        .vector_valid_o(vvalid), .reset_req_o(rreq), .clock_run_o());

    task finish_test;
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task vchk(input logic v, input logic [15:0] e);
        repeat (6) @(posedge clk_i);
        if (v) chk({15'h0, vvalid, vec}, {16'h1, e});
        else chk({31'h0, vvalid}, 32'h0);
    endtask : vchk

    always @(posedge clk_i) if (++cycles > 5000) begin errors++; finish_test(); end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1;
        apb(0, `RIVC_OPT_ADDR, 0); chk(r, {24'h0, `RIVC_OPT_RESET});
        apb(1, `RIVC_OPT_ADDR, 32'hFF); apb(0, `RIVC_OPT_ADDR, 0); chk(r, 32'hFB);
        apb(1, `RIVC_OPT_ADDR, 32'h00); apb(0, `RIVC_OPT_ADDR, 0); chk(r, 32'h33);
        apb(0, `RIVC_PROMO_ADDR, 0); chk(r, 32'h6);
        apb(1, `RIVC_SRCEN_ADDR, 32'h07FFFFFF);
        for (int i = 0; i < 8; i++) begin
            cpu.drive(0, 1, 0, 1, 7'h7F, src[i]); vchk(1, exv[i]);
        end
        cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0022); vchk(1, `RIVC_VEC_RTI);
        cpu.drive(1, 1, 0, 1, 7'h7F, 14'h0022); vchk(0, 0);
        cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0022);
        apb(1, `RIVC_PROMO_ADDR, 0); apb(0, `RIVC_PROMO_ADDR, 0); chk(r, 32'h6);
        cpu.drive(1, 1, 0, 1, 7'h7F, 14'h0022);
        apb(1, `RIVC_PROMO_ADDR, 0); apb(0, `RIVC_PROMO_ADDR, 0); chk(r, 32'h0);
        cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0022); vchk(1, `RIVC_VEC_TOV);
        apb(1, `RIVC_SRCEN_ADDR, 0); cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0020); vchk(0, 0);
        apb(1, `RIVC_SRCEN_ADDR, 32'h07FFFFFF);
        cpu.drive(0, 1, 0, 1, 7'h7B, 14'h0); vchk(1, `RIVC_VEC_IRQ);
        cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0);
        apb(0, `RIVC_KBST_ADDR, 0); chk(r, 32'h04);
        apb(0, `RIVC_KBST_ADDR, 0); chk(r, 32'h00);
        cpu.drive(1, 0, 0, 0, 7'h7F, 14'h0); vchk(1, `RIVC_VEC_NMI);
        cpu.drive(1, 1, 1, 1, 7'h7F, 14'h0); vchk(1, `RIVC_VEC_SWI);
        cpu.drive(1, 1, 0, 1, 7'h7F, 14'h0);
        slow <= 1; repeat (300) @(posedge clk_i); chk({31'h0, rreq}, 0);
        apb(1, `RIVC_OPT_ADDR, 32'h08); apb(0, `RIVC_OPT_ADDR, 0); chk(r, 32'h3B);
        repeat (300) @(posedge clk_i);
        chk({15'h0, rreq, vec}, {16'h1, `RIVC_VEC_CLKMON});
        slow <= 0; ext_n <= 0; repeat (6) @(posedge clk_i);
        chk({15'h0, rreq, vec}, {16'h1, `RIVC_VEC_RESET});
        ext_n <= 1; repeat (8) @(posedge clk_i);
        cpu.drive(0, 1, 0, 1, 7'h7F, 14'h0); cpu.async_serial_port(5'h10); cpu.async_serial_port(5'h00);
        vchk(1, `RIVC_VEC_SCI);
        apb(0, `RIVC_SCIST_ADDR, 0); chk(r, 32'h1);
        apb(0, `RIVC_SCIDAT_ADDR, 0); apb(0, `RIVC_SCIST_ADDR, 0); chk(r, 32'h0);
        vchk(0, 0);
        irq_n <= 0; vchk(1, `RIVC_VEC_IRQ);
        apb(0, `RIVC_KBST_ADDR, 0); chk(r, 32'h80);
        apb(0, `RIVC_KBST_ADDR, 0); chk(r, 32'h00);
        irq_n <= 1; illop <= 1; vchk(1, `RIVC_VEC_ILLOP);
        illop <= 0;
        apb(0, 12'h104, 0); chk({31'h0, last_err}, 32'h1);
        finish_test();
    end
endmodule : test_reset_interrupt_vector_control

bind rivc_core rivc_core_asserts chk_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .i_mask_i(i_mask_i), .x_mask_i(x_mask_i),
    .swi_i(swi_i), .ext_reset_n_i(ext_reset_n_i), .vector_o(vector_o),
    .vector_valid_o(vector_valid_o), .reset_req_o(reset_req_o));
